// *** ctl_pkg.sv ***
package ctl_pkg;

  // rate defaults when no rate byte or waiting byte was announced
  localparam logic [11:0] DEF_CLOCK_RATE = 12'h174;
  localparam logic [6:0]  DEF_BAUD_ADJ   = 7'h01;
  localparam logic [7:0]  DEF_WAIT_INT   = 8'h0A;
  localparam logic [31:0] WWT_MULT       = 32'h000003C0;

  // frame positions in half etu counted from the start edge
  localparam logic [5:0] H_START_CHK = 6'h01;
  localparam logic [5:0] H_TX_DATA0  = 6'h02;
  localparam logic [5:0] H_DATA0     = 6'h03;
  localparam logic [5:0] H_TX_PAR    = 6'h12;
  localparam logic [5:0] H_PARITY    = 6'h13;
  localparam logic [5:0] H_GUARD     = 6'h14;
  localparam logic [5:0] H_ERR_ON    = 6'h15;
  localparam logic [5:0] H_TX_CHK    = 6'h16;
  localparam logic [5:0] H_CHAR_GAP  = 6'h18;
  localparam logic [5:0] H_RETRY_GAP = 6'h1E;
  localparam logic [5:0] H_SAT       = 6'h3F;

  // command header layout
  localparam logic [2:0] HDR_INS_IDX = 3'h1;
  localparam logic [2:0] HDR_LAST    = 3'h4;

  // procedure and status codes
  localparam logic [7:0] NULL_BYTE  = 8'h60;
  localparam logic [3:0] SW_GROUP_6 = 4'h6;
  localparam logic [3:0] SW_GROUP_9 = 4'h9;

  typedef enum logic [2:0] {
    T_HDR  = 3'b000,
    T_PROC = 3'b001,
    T_SW2  = 3'b010,
    T_DIN  = 3'b011,
    T_DOUT = 3'b100
  } ctl_t0_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_RX   = 2'b01,
    L_TX   = 2'b10
  } ctl_line_t;

  typedef struct packed {
    logic        inverse;
    logic        low_imp;
    logic        rate_known;
    logic [11:0] clock_rate_factor;
    logic [6:0]  baud_adjust_factor;
    logic        wait_known;
    logic [7:0]  waiting_integer;
  } ctl_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       is_header;
  } ctl_rx_t;

  // inverse convention sends the most significant bit first
  function automatic logic [2:0] ctl_bit_index(input logic [2:0] k,
                                               input logic inv);
    ctl_bit_index = inv ? 3'h7 - k : k;
  endfunction : ctl_bit_index

endpackage : ctl_pkg

// *** ctl_fifo.sv ***
`timescale 1ns/1ps
module ctl_fifo
  import ctl_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
)
(
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
  } ctl_fifo_state_t;

  ctl_fifo_state_t fifo_reg;
  ctl_fifo_state_t fifo_next;
  logic            push;
  logic            pop;

  assign in_ready_out  = (fifo_reg.count != (AW+1)'(DEPTH));
  assign out_valid_out = (fifo_reg.count != '0);
  assign out_data_out  = fifo_reg.mem[fifo_reg.rd];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && out_valid_out;

  always_comb
  begin
    fifo_next = fifo_reg;
    if (push)
    begin
      fifo_next.mem[fifo_reg.wr] = in_data_in;
      fifo_next.wr = (fifo_reg.wr == AW'(DEPTH-1)) ? '0 : fifo_reg.wr + 1'b1;
    end
    if (pop)
      fifo_next.rd = (fifo_reg.rd == AW'(DEPTH-1)) ? '0 : fifo_reg.rd + 1'b1;
    fifo_next.count = fifo_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      fifo_reg <= '0;
    else
      fifo_reg <= fifo_next;
  end

endmodule : ctl_fifo

// *** ctl_link.sv ***
`timescale 1ns/1ps
module ctl_link
  import ctl_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 4
)
(
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       io_line_in,
  output logic            io_line_out,
  output logic            io_line_oe_out,
  input  wire ctl_cfg_t   cfg_in,
  input  wire logic       dir_to_terminal_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output ctl_rx_t         rx_out,
  output logic            rx_valid_out,
  output logic            parity_err_out,
  output logic            retry_out,
  output ctl_t0_t         t0_phase_out
);

  typedef struct packed {
    logic [2:0]  sync;
    logic        line;
    logic        line_prev;
    ctl_line_t   lmode;
    logic [12:0] acc;
    logic [5:0]  half;
    logic [7:0]  shift;
    logic        par;
    logic        err;
    logic [7:0]  tx_byte;
    ctl_t0_t     t0;
    logic [2:0]  hdr_idx;
    logic [7:0]  instruction_byte;
    logic [8:0]  len;
    logic        single;
    logic        dir_out;
    logic [31:0] wwt_cnt;
    logic        io_out;
    logic        io_oe;
    ctl_rx_t     rx;
    logic        rx_valid;
    logic        perr;
    logic        retry;
  } ctl_state_t;

  ctl_state_t  s;
  ctl_state_t  n;
  logic [11:0] f_eff;
  logic [6:0]  d_eff;
  logic [7:0]  wi;
  logic [31:0] wwt_limit;
  logic [12:0] sum;
  logic        tick;
  logic        tx_start;
  logic        tx_done;
  logic        my_turn;
  logic        lb;
  logic        lvl;
  logic [2:0]  k;
  logic [7:0]  fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;

  // tx bytes wait here; tx_ready_out stalls the producer when full
  ctl_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_data_in    (tx_data_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop)
  );

  always_comb
  begin
    n        = s;
    tick     = 1'b0;
    tx_start = 1'b0;
    tx_done  = 1'b0;
    fifo_pop = 1'b0;
    lvl      = 1'b1;
    k        = 3'h0;
    n.rx_valid = 1'b0;
    n.perr     = 1'b0;
    n.retry    = 1'b0;
    f_eff = cfg_in.rate_known ? cfg_in.clock_rate_factor : DEF_CLOCK_RATE;
    d_eff = cfg_in.rate_known ? cfg_in.baud_adjust_factor : DEF_BAUD_ADJ;
    if (d_eff == 7'h00)
      d_eff = DEF_BAUD_ADJ;
    wi = cfg_in.wait_known ? cfg_in.waiting_integer : DEF_WAIT_INT;
    wwt_limit = WWT_MULT * 32'(wi) * 32'(f_eff);
    // glitch filter: only second and third stage are compared
    n.sync = {s.sync[1:0], io_line_in};
    if (s.sync[1] == s.sync[2])
      n.line = s.sync[2];
    n.line_prev = s.line;
    lb = cfg_in.inverse ? ~s.line : s.line;
    // fractional half-etu timebase, avoids a divider
    sum = s.acc + {5'h00, d_eff, 1'b0};
    if (sum >= {1'b0, f_eff})
    begin
      n.acc = sum - {1'b0, f_eff};
      tick  = 1'b1;
    end
    else
      n.acc = sum;
    if (tick && s.half != H_SAT)
      n.half = s.half + 6'h01;
    if (s.wwt_cnt != 32'hFFFFFFFF)
      n.wwt_cnt = s.wwt_cnt + 32'h00000001;
    my_turn = (s.t0 == T_PROC) || (s.t0 == T_SW2) || (s.t0 == T_DOUT);
    case (s.lmode)
      L_IDLE:
      begin
        if (s.line_prev && !s.line)
        begin
          n.lmode   = L_RX;
          n.acc     = 13'h0000;
          n.half    = 6'h00;
          n.wwt_cnt = 32'h00000000;
          n.shift   = 8'h00;
          n.par     = 1'b0;
          n.err     = 1'b0;
        end
        else if (my_turn && s.half >= H_CHAR_GAP &&
                 (fifo_valid || (s.t0 == T_PROC &&
                  s.wwt_cnt >= (wwt_limit >> 1))))
        begin
          tx_start  = 1'b1;
          fifo_pop  = fifo_valid;
          n.tx_byte = fifo_valid ? fifo_data : NULL_BYTE;
          n.lmode   = L_TX;
          n.acc     = 13'h0000;
          n.half    = 6'h00;
          n.wwt_cnt = 32'h00000000;
          n.err     = 1'b0;
        end
      end
      L_RX:
      begin
        if (tick)
        begin
          if (n.half == H_START_CHK && s.line)
            n.lmode = L_IDLE;
          else if (n.half >= H_DATA0 && n.half < H_PARITY && n.half[0])
          begin
            k = 3'((n.half - H_DATA0) >> 1);
            n.shift[ctl_bit_index(k, cfg_in.inverse)] = lb;
            n.par = s.par ^ lb;
          end
          else if (n.half == H_PARITY)
            n.err = s.par ^ lb;
          else if (n.half == H_CHAR_GAP)
          begin
            n.lmode = L_IDLE;
            if (s.err)
              n.perr = 1'b1;
            else
            begin
              n.rx_valid = 1'b1;
              n.rx       = '{data: s.shift, is_header: s.t0 == T_HDR};
              case (s.t0)
                T_HDR:
                begin
                  if (s.hdr_idx == HDR_INS_IDX)
                    n.instruction_byte = s.shift;
                  if (s.hdr_idx == HDR_LAST)
                  begin
                    n.len     = (s.shift == 8'h00) ? 9'h100 : {1'b0, s.shift};
                    n.dir_out = dir_to_terminal_in;
                    n.hdr_idx = 3'h0;
                    n.t0      = T_PROC;
                  end
                  else
                    n.hdr_idx = s.hdr_idx + 3'h1;
                end
                T_DIN:
                begin
                  n.len = s.len - 9'h001;
                  if (s.single || s.len == 9'h001)
                    n.t0 = T_PROC;
                end
                default:
                  n.t0 = s.t0;
              endcase
            end
          end
        end
      end
      L_TX:
      begin
        if (tick)
        begin
          if (n.half == H_TX_CHK && !s.line)
            n.err = 1'b1;
          if (n.half == H_CHAR_GAP && !s.err)
          begin
            tx_done = 1'b1;
            n.lmode = L_IDLE;
            case (s.t0)
              T_PROC:
              begin
                if (s.tx_byte == s.instruction_byte && s.len != 9'h000)
                begin
                  n.t0     = s.dir_out ? T_DOUT : T_DIN;
                  n.single = 1'b0;
                end
                else if (s.tx_byte == ~s.instruction_byte && s.len != 9'h000)
                begin
                  n.t0     = s.dir_out ? T_DOUT : T_DIN;
                  n.single = 1'b1;
                end
                else if (s.tx_byte != NULL_BYTE &&
                         (s.tx_byte[7:4] == SW_GROUP_6 ||
                          s.tx_byte[7:4] == SW_GROUP_9))
                  n.t0 = T_SW2;
              end
              T_SW2:
                n.t0 = T_HDR;
              T_DOUT:
              begin
                n.len = s.len - 9'h001;
                if (s.single || s.len == 9'h001)
                  n.t0 = T_PROC;
              end
              default:
                n.t0 = s.t0;
            endcase
          end
          else if (n.half == H_RETRY_GAP)
          begin
            // repeat leaves at least 2 etu after the longest error pulse
            tx_start  = 1'b1;
            n.retry   = 1'b1;
            n.acc     = 13'h0000;
            n.half    = 6'h00;
            n.wwt_cnt = 32'h00000000;
            n.err     = 1'b0;
          end
        end
      end
      default:
        n.lmode = L_IDLE;
    endcase
    // pin drive follows the next state so outputs line up with it
    n.io_out = 1'b1;
    n.io_oe  = 1'b0;
    case (n.lmode)
      L_TX:
      begin
        if (n.half < H_TX_DATA0)
          lvl = 1'b0;
        else if (n.half < H_TX_PAR)
        begin
          k   = 3'((n.half - H_TX_DATA0) >> 1);
          lvl = n.tx_byte[ctl_bit_index(k, cfg_in.inverse)] ^
                cfg_in.inverse;
        end
        else if (n.half < H_GUARD)
          lvl = (^n.tx_byte) ^ cfg_in.inverse;
        if (n.half < H_GUARD)
        begin
          n.io_out = lvl;
          n.io_oe  = cfg_in.low_imp | ~lvl;
        end
        else if (n.half >= H_CHAR_GAP)
          n.io_oe = cfg_in.low_imp;
      end
      L_RX:
      begin
        if (n.err && n.half >= H_ERR_ON && n.half < H_CHAR_GAP)
        begin
          n.io_out = 1'b0;
          n.io_oe  = 1'b1;
        end
      end
      default:
        n.io_oe = cfg_in.low_imp && ((n.t0 == T_PROC) ||
                  (n.t0 == T_SW2) || (n.t0 == T_DOUT));
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s          <= '0;
      s.sync     <= 3'h7;
      s.line     <= 1'b1;
      s.line_prev <= 1'b1;
      s.half     <= H_SAT;
      s.io_out   <= 1'b1;
    end
    else
      s <= n;
  end

  assign io_line_out    = s.io_out;
  assign io_line_oe_out = s.io_oe;
  assign rx_out         = s.rx;
  assign rx_valid_out   = s.rx_valid;
  assign parity_err_out = s.perr;
  assign retry_out      = s.retry;
  assign t0_phase_out   = s.t0;

  default clocking ctl_cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  start_bit_low_a: assert property (
    s.lmode == L_TX && s.half < H_TX_DATA0 |-> !io_line_out && io_line_oe_out)
    else $error("start bit not driven low");
  parity_even_a: assert property (
    s.lmode == L_TX && s.half == H_TX_PAR && !cfg_in.inverse
    |-> io_line_out == ^s.tx_byte)
    else $error("parity bit not even");
  idle_high_a: assert property (
    s.lmode == L_IDLE |-> io_line_out)
    else $error("idle line not high");
  guard_release_a: assert property (
    s.lmode == L_TX && s.half >= H_GUARD && s.half < H_CHAR_GAP
    |-> !io_line_oe_out)
    else $error("line driven in error window");
  turn_hold_a: assert property (
    s.lmode == L_IDLE && cfg_in.low_imp && s.t0 == T_PROC
    |-> io_line_oe_out && io_line_out)
    else $error("idle line not held high");
  char_gap_a: assert property (
    tx_start && s.lmode == L_IDLE |-> s.half >= H_CHAR_GAP)
    else $error("start edges closer than twelve etu");
  wwt_bound_a: assert property (
    s.t0 == T_PROC && s.lmode == L_IDLE |-> s.wwt_cnt <= wwt_limit)
    else $error("work waiting limit exceeded");
  err_pulse_a: assert property (
    s.lmode == L_RX && s.err && s.half == H_ERR_ON
    |-> !io_line_out && io_line_oe_out ##1 !io_line_out)
    else $error("parity error not signalled");
  header_done_a: assert property (
    s.lmode == L_RX && s.t0 == T_HDR && s.hdr_idx == HDR_LAST && tick &&
    n.half == H_CHAR_GAP && !s.err
    |=> s.t0 == T_PROC && rx_valid_out && rx_out.is_header)
    else $error("header end not followed by procedure phase");
  ack_all_a: assert property (
    tx_done && s.t0 == T_PROC && s.tx_byte == s.instruction_byte && s.len != 9'h000
    |=> (s.t0 == T_DIN || s.t0 == T_DOUT) && !s.single)
    else $error("ack did not open data phase");
  ack_one_a: assert property (
    tx_done && s.t0 == T_PROC && s.tx_byte == ~s.instruction_byte && s.len != 9'h000
    |=> s.single && $past(s.len) == s.len)
    else $error("single ack not recorded");
  retry_cause_a: assert property (
    s.retry |-> $past(s.err) && s.lmode == L_TX)
    else $error("repeat without error indication");

  tx_char_c: cover property (tx_done);
  null_sent_c: cover property (tx_done && s.tx_byte == NULL_BYTE);
  data_out_c: cover property (s.t0 == T_DOUT);
  retry_c: cover property (s.retry);

endmodule : ctl_link

// *** ctl_term_model.sv ***
`timescale 1ns/1ps
module ctl_term_model
  import ctl_pkg::*;
(
  input  wire logic  clock_in,
  input  wire logic  io_wire_in,
  input  wire logic  inverse_in,
  input  wire logic  nack_in,
  input  int         etu_in,
  output logic       drive_low_out,
  output logic [7:0] got_data_out,
  output logic       got_par_ok_out,
  output int         got_count_out,
  output int         gap_out
);
  logic sending;
  int   cyc;
  int   last_start;

  initial
  begin
    drive_low_out = 1'b0;
    sending = 1'b0;
    got_count_out = 0;
    gap_out = 0;
    last_start = 0;
    cyc = 0;
  end

  always @(posedge clock_in)
    cyc <= cyc + 1;

  // frame bit k: 0 start, 1..8 data, 9 parity
  function automatic logic lvl(input logic [7:0] d, input int k,
                               input logic bad);
    logic b;
    if (k == 0)
      return 1'b0;
    b = (k == 9) ? (^d ^ bad) : d[inverse_in ? 8 - k : k - 1];
    return inverse_in ? ~b : b;
  endfunction : lvl

  // open drain only: the pull-up gives every high, so no idle drive
  task automatic send(input logic [7:0] d, input logic bad);
    sending = 1'b1;
    @(negedge clock_in);
    last_start = cyc;
    for (int k = 0; k < 10; k++)
    begin
      drive_low_out = ~lvl(d, k, bad);
      repeat (etu_in) @(negedge clock_in);
    end
    drive_low_out = 1'b0;
    // deaf only through the error window, so a reply at 12 etu is caught
    repeat (etu_in) @(negedge clock_in);
    sending = 1'b0;
    repeat (2 * etu_in) @(negedge clock_in);
  endtask : send

  always
  begin : rx_proc
    logic [9:0] f;
    @(negedge io_wire_in);
    if (!sending)
    begin
      gap_out = cyc - last_start;
      last_start = cyc;
      for (int k = 0; k < 10; k++)
      begin
        repeat (k == 0 ? etu_in / 2 : etu_in) @(posedge clock_in);
        f[k] = inverse_in ? ~io_wire_in : io_wire_in;
      end
      for (int k = 0; k < 8; k++)
        got_data_out[inverse_in ? 7 - k : k] = f[k + 1];
      got_par_ok_out = ~^f[9:1];
      if (!got_par_ok_out || nack_in)
      begin
        repeat (etu_in) @(negedge clock_in);
        drive_low_out = 1'b1;
        repeat (etu_in * 3 / 2) @(negedge clock_in);
        drive_low_out = 1'b0;
      end
      got_count_out = got_count_out + 1;
    end
  end
endmodule : ctl_term_model

// *** card_t0_char_link_bench.sv ***
`timescale 1ns/1ps
module card_t0_char_link_bench;
  import ctl_pkg::*;
  logic       clock_in;
  logic       rst_n_in;
  logic       io_wire;
  logic       io_line_out;
  logic       io_line_oe_out;
  ctl_cfg_t   cfg;
  logic       dir_to_term;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready_out;
  ctl_rx_t    rx_out;
  logic       rx_valid_out;
  logic       parity_err_out;
  logic       retry_out;
  ctl_t0_t    t0_phase_out;
  logic       term_low;
  logic       nack;
  logic [7:0] got_data;
  logic       got_par_ok;
  logic       got_rx;
  logic       got_perr;
  logic       retry_seen;
  logic       ok;
  ctl_rx_t    rx_seen;
  int         got_count;
  int         gap;
  int         etu;
  int         n_wait;
  int         low_at;
  int         fail_count;
  int         cmp_count;

  assign io_wire = (io_line_oe_out ? io_line_out : 1'b1) & ~term_low;

  ctl_link DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .io_line_in(io_wire), .io_line_out(io_line_out),
    .io_line_oe_out(io_line_oe_out), .cfg_in(cfg),
    .dir_to_terminal_in(dir_to_term), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready_out),
    .rx_out(rx_out), .rx_valid_out(rx_valid_out),
    .parity_err_out(parity_err_out), .retry_out(retry_out),
    .t0_phase_out(t0_phase_out));

  ctl_term_model u_term (.clock_in(clock_in), .io_wire_in(io_wire),
    .inverse_in(cfg.inverse), .nack_in(nack), .etu_in(etu),
    .drive_low_out(term_low), .got_data_out(got_data),
    .got_par_ok_out(got_par_ok), .got_count_out(got_count),
    .gap_out(gap));

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
    if (retry_out === 1'b1)
      retry_seen <= 1'b1;

  task automatic fail(input string m);
    fail_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("byte %h expected %h", got, exp));
  endtask : check8

  task automatic check1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("flag %b expected %b", got, exp));
  endtask : check1

  task automatic check_ph(input ctl_t0_t got, input ctl_t0_t exp);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("phase %0d expected %0d", got, exp));
  endtask : check_ph

  // etu is 372 card clocks unless a rate factor is given, baud adjust 1
  task automatic start(input logic inv, input logic known, input int f);
    cfg = '0;
    cfg.inverse = inv;
    cfg.low_imp = 1'b1;
    cfg.rate_known = known;
    cfg.clock_rate_factor = 12'(f);
    cfg.baud_adjust_factor = 7'h01;
    etu = known ? f : 372;
    rst_n_in = 1'b0;
    tx_valid = 1'b0;
    nack = 1'b0;
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
  endtask : start

  task automatic wait_dut;
    got_rx = 1'b0;
    got_perr = 1'b0;
    low_at = -1;
    for (n_wait = 0; n_wait < 14 * etu; n_wait++)
    begin
      @(negedge clock_in);
      if (low_at < 0 && io_line_oe_out === 1'b1 && io_line_out === 1'b0)
        low_at = n_wait;
      if (rx_valid_out === 1'b1 || parity_err_out === 1'b1)
      begin
        got_rx = rx_valid_out;
        got_perr = parity_err_out;
        rx_seen = rx_out;
        break;
      end
    end
  endtask : wait_dut

  task automatic term_byte(input logic [7:0] d, input logic bad);
    fork
      u_term.send(d, bad);
      wait_dut();
    join
    check1(got_perr, bad);
    check1(got_rx, ~bad);
    check1(n_wait >= 12 * etu && n_wait <= 12 * etu + 8, 1'b1);
    if (bad)
      check1(low_at >= 21 * etu / 2 && low_at <= 21 * etu / 2 + 8, 1'b1);
    else
      check8(rx_seen.data, d);
  endtask : term_byte

  task automatic header(input logic [7:0] instruction_byte, input logic [7:0] len);
    logic [7:0] h [5];
    h = '{8'h00, instruction_byte, 8'h00, 8'h00, len};
    for (int i = 0; i < 5; i++)
    begin
      term_byte(h[i], 1'b0);
      check1(rx_seen.is_header, 1'b1);
    end
    check_ph(t0_phase_out, T_PROC);
  endtask : header

  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    ok = tx_ready_out;
    @(negedge clock_in);
    tx_valid = 1'b0;
    @(negedge clock_in);
  endtask : push

  task automatic wait_card(input logic [7:0] d, input int lim);
    int c0;
    c0 = got_count;
    for (int n = 0; n < lim && got_count == c0; n++)
      @(negedge clock_in);
    check1(got_count != c0, 1'b1);
    check8(got_data, d);
    check1(got_par_ok, 1'b1);
    check1(gap >= 12 * etu, 1'b1);
    repeat (3 * etu) @(negedge clock_in);
  endtask : wait_card

  task automatic sc_default_rate;
    start(1'b0, 1'b0, 0);
    term_byte(8'hA5, 1'b0);
  endtask : sc_default_rate

  task automatic sc_parity;
    start(1'b0, 1'b1, 32);
    term_byte(8'h3C, 1'b1);
    term_byte(8'h3C, 1'b0);
    check_ph(t0_phase_out, T_HDR);
  endtask : sc_parity

  // fifo filled ahead of the command; card may only send once in PROC
  task automatic sc_out_all;
    logic [7:0] q [4];
    start(1'b0, 1'b1, 32);
    dir_to_term = 1'b1;
    q = '{8'hB0, 8'h11, 8'h22, 8'h90};
    for (int i = 0; i < 4; i++)
    begin
      push(q[i]);
      check1(ok, 1'b1);
    end
    push(8'h00);
    check1(ok, 1'b0);
    header(8'hB0, 8'h02);
    wait_card(8'hB0, 40 * etu);
    check_ph(t0_phase_out, T_DOUT);
    wait_card(8'h11, 40 * etu);
    wait_card(8'h22, 40 * etu);
    check_ph(t0_phase_out, T_PROC);
    push(8'h00);
    wait_card(8'h90, 40 * etu);
    check_ph(t0_phase_out, T_SW2);
    wait_card(8'h00, 40 * etu);
    check_ph(t0_phase_out, T_HDR);
  endtask : sc_out_all

  task automatic sc_in_one;
    start(1'b1, 1'b1, 32);
    cfg.low_imp = 1'b0;
    dir_to_term = 1'b0;
    header(8'hC4, 8'h02);
    push(8'h3B);
    wait_card(8'h3B, 40 * etu);
    check_ph(t0_phase_out, T_DIN);
    term_byte(8'h55, 1'b0);
    check_ph(t0_phase_out, T_PROC);
    retry_seen = 1'b0;
    nack = 1'b1;
    push(8'h61);
    wait_card(8'h61, 40 * etu);
    nack = 1'b0;
    wait_card(8'h61, 40 * etu);
    check1(retry_seen, 1'b1);
    check1(gap >= 15 * etu - 8, 1'b1);
    check_ph(t0_phase_out, T_SW2);
    push(8'h10);
    wait_card(8'h10, 40 * etu);
    check_ph(t0_phase_out, T_HDR);
    header(8'hC0, 8'h10);
  endtask : sc_in_one

  task automatic sc_null;
    start(1'b0, 1'b1, 32);
    cfg.wait_known = 1'b1;
    cfg.waiting_integer = 8'h01;
    header(8'hA4, 8'h00);
    wait_card(NULL_BYTE, 600 * etu);
    check_ph(t0_phase_out, T_PROC);
    push(8'h6C);
    wait_card(8'h6C, 40 * etu);
    check_ph(t0_phase_out, T_SW2);
    push(8'h05);
    wait_card(8'h05, 40 * etu);
    check_ph(t0_phase_out, T_HDR);
    header(8'hA4, 8'h05);
  endtask : sc_null

  task automatic results;
    $display("compares %0d failures %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  initial
  begin
    #1000000;
    fail("watchdog expired");
    results();
  end

  initial
  begin
    fail_count = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    cfg = '0;
    dir_to_term = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    nack = 1'b0;
    retry_seen = 1'b0;
    etu = 372;
    sc_default_rate();
    sc_parity();
    sc_out_all();
    sc_in_one();
    sc_null();
    results();
  end
endmodule : card_t0_char_link_bench
